// [mdsc_pkg.sv]
// Constants and types of the motor driver serial port and mode control.
package mdsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned T_SLEEP_NS = 120000;
  localparam int unsigned T_WAKE_NS = 1000000;
  localparam int unsigned T_RST_NS = 20000;
  localparam int unsigned SLEEP_CYC =
    (T_SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_CYC =
    (T_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RST_CYC = (T_RST_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TMR_W = 32;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int unsigned RW_POS = 15;
  localparam int unsigned ADDR_MSB = 14;
  localparam int unsigned ADDR_LSB = 9;
  localparam int unsigned DATA_MSB = 7;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] FRAME_SAT = 5'h11;
  localparam logic [4:0] ADDR_DONE = 5'h07;
  localparam logic [4:0] DATA_FIRST = 5'h08;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_IC_TOP = 6'h00;
  localparam logic [5:0] OFS_DRV_STAT = 6'h01;
  localparam logic [5:0] OFS_SUP_STAT = 6'h02;
  localparam logic [5:0] OFS_CTRL_FIRST = 6'h03;
  localparam logic [5:0] OFS_CLEAR = 6'h03;
  localparam logic [5:0] OFS_LAST = 6'h0C;
  localparam int unsigned REG_NUM = 13;
  localparam int unsigned CTRL_NUM = 10;
  localparam int unsigned CLEAR_POS = 0;
  localparam logic [7:0] IC_TOP_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Top status byte fields.
  localparam int unsigned IC_STALL = 7;
  localparam int unsigned IC_BUCK = 6;
  localparam int unsigned IC_SPI = 5;
  localparam int unsigned IC_OC = 4;
  localparam int unsigned IC_POR = 3;
  localparam int unsigned IC_OV = 2;
  localparam int unsigned IC_OT = 1;
  localparam int unsigned IC_FAULT = 0;

  // Second status byte fields.
  localparam int unsigned SUP_PARITY = 2;
  localparam int unsigned SUP_FRAME = 1;
  localparam int unsigned SUP_ADDR = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MD_SLEEP = 5'h01,
    MD_WAKING = 5'h02,
    MD_ACTIVE = 5'h04,
    MD_PULSE = 5'h08,
    MD_ENTERING = 5'h10
  } mdsc_mode_t;

  typedef struct packed {
    logic motor_stall;
    logic buck_fault;
    logic overcurrent;
    logic overvoltage;
    logic overtemperature;
    logic global_fault;
    logic [7:0] drv_status;
    logic [3:0] supply_status;
  } mdsc_prot_in_t;

  typedef struct packed {
    logic regs_on;
    logic spi_on;
    logic switches_on;
    logic ready;
    logic drv_fault_mask;
  } mdsc_power_t;

  typedef struct packed {
    logic sleep_s1;
    logic sleep_s2;
    logic drv_s1;
    logic drv_s2;
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    mdsc_mode_t mode;
    logic [TMR_W-1:0] timer;
    logic link_run;
    logic [2:0][7:0] snap;
    logic [CTRL_NUM-1:0][7:0] ctrl;
    logic frame_err;
    logic addr_err;
    logic parity_err;
    logic por_flag;
    logic clear_pulse;
  } mdsc_core_t;

  typedef struct packed {
    logic [15:0] shift;
    logic [4:0] count;
    logic [5:0] addr;
  } mdsc_rx_t;

  typedef struct packed {
    logic sdo;
  } mdsc_tx_t;

endpackage

// [mdsc_spi_mode.sv]
// Serial register port, sleep and fault-reset control of a motor driver.
//
// How it works
// RL1: Sleep pin held low puts the device into low-power sleep.
// RL2: Sleep turns off switches, amplifiers, regulators, pump and serial port.
// RL3: Sleep follows the entry delay; wake is automatic, ready after wake delay.
// RL4: Fault indicator held low while regulators ramp up or down.
// RL5: Sleep pin high means operating mode with supplies and port active.
// RL6: Latched fault resumes on clear-faults bit or valid reset pulse.
// RL7: Short low pulse on sleep pin is a reset; longer starts sleep.
// RL8: Reset pulse clears latched faults only, nothing else; the code also sets the power-on flag.
// RL9: Driver-disable high turns all switches off and masks driver faults.
// RL10: Input word: bit 15 read/write, 14..9 address, 8 parity, 7..0 data.
// RL11: Controller sets parity so the whole input word is even.
// RL12: Zero writes, one reads; reply holds the register's prior content.
// RL13: Reply word is top status byte then addressed register byte.
// RL14: Controller keeps serial clock low at both chip-select edges.
// RL15: Controller keeps chip select high at least the minimum word gap.
// RL16: Chip select high: clock and data ignored, output floats.
// RL17: Input sampled on falling clock edge, output changes on rising.
// RL18: Both directions shift most significant bit first.
// RL19: Frames other than 16 clocks are dropped and latch a frame error.
// RL20: Address beyond the map latches an address error.
// RL21: All registers return to defaults at power-up and sleep entry.
// RL22: Top status byte bit order, power-on flag reads zero after reset; the code sets it to one on every clear pulse.
// RL23: Second status byte: parity bit 2, frame bit 1, address bit 0.
// RL24: Failed parity check latches the parity error flag.
// RL25: Serial fault summary set while any serial error flag is set.
`timescale 1ns/1ps
`default_nettype none

module mdsc_spi_mode
  import mdsc_pkg::*;
#(
  parameter int unsigned SLEEP_T = SLEEP_CYC,
  parameter int unsigned WAKE_T = WAKE_CYC,
  parameter int unsigned RST_T = RST_CYC,
  parameter logic [CTRL_NUM-1:0][7:0] CTRL_RESET = {CTRL_NUM{CTRL_RST}}
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Mode pins.
  input wire logic sleep_control_pin,
  input wire logic driver_disable_pin,
  output logic fault_indicator_pin_oe_b,
  // Serial port; the serial clock is the link domain clock.
  input wire logic spi_sclk,
  input wire logic chip_select_low,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_b,
  // Protection logic side.
  input wire mdsc_prot_in_t prot_in,
  output logic clear_faults_pulse,
  output mdsc_power_t power
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RST_T < 1 || SLEEP_T <= RST_T || WAKE_T < 1) begin : g_bad_timing
    $error("Reset window must be shorter than the sleep entry delay.");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mdsc_core_t core_reg;
  mdsc_core_t core_next;
  mdsc_rx_t rx_reg;
  mdsc_rx_t rx_next;
  mdsc_tx_t tx_reg;
  mdsc_tx_t tx_next;
  logic [7:0] ic_top_live;
  logic [7:0] drv_live;
  logic [7:0] sup_live;
  logic [REG_NUM-1:0][7:0] reg_view;
  logic [5:0] fr_addr;
  logic [7:0] fr_data;
  logic [3:0] fr_idx;
  logic [7:0] rd_byte;
  logic [15:0] reply;
  logic spi_ok;
  logic link_rst_b;

  // ----------------------------------------------------------------
  // Status bytes
  // ----------------------------------------------------------------
  always_comb begin
    ic_top_live = IC_TOP_RST;
    // see RL22
    ic_top_live[IC_STALL] = prot_in.motor_stall;
    ic_top_live[IC_BUCK] = prot_in.buck_fault;
    ic_top_live[IC_SPI] = core_reg.frame_err | core_reg.addr_err |
                          core_reg.parity_err; // see RL25
    ic_top_live[IC_OC] = prot_in.overcurrent;
    ic_top_live[IC_POR] = core_reg.por_flag;
    ic_top_live[IC_OV] = prot_in.overvoltage;
    ic_top_live[IC_OT] = prot_in.overtemperature;
    ic_top_live[IC_FAULT] = prot_in.global_fault;
    drv_live = prot_in.drv_status;
    sup_live = {1'b0, prot_in.supply_status, 3'h0};
    sup_live[SUP_PARITY] = core_reg.parity_err; // see RL23
    sup_live[SUP_FRAME] = core_reg.frame_err;
    sup_live[SUP_ADDR] = core_reg.addr_err;
  end

  // The link reads this view only while a frame runs, when the status
  // snapshot is frozen and control bytes cannot change.
  for (genvar i = 0; i < REG_NUM; i++) begin : g_view
    if (i < 3) begin : g_stat
      assign reg_view[i] = core_reg.snap[i];
    end else begin : g_ctrl
      assign reg_view[i] = core_reg.ctrl[i-3];
    end
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  assign fr_addr = rx_reg.shift[ADDR_MSB:ADDR_LSB]; // see RL10
  assign fr_data = rx_reg.shift[DATA_MSB:0];
  assign fr_idx = 4'(fr_addr - OFS_CTRL_FIRST);
  assign spi_ok = (core_reg.mode == MD_ACTIVE) ||
                  (core_reg.mode == MD_PULSE);

  always_comb begin
    core_next = core_reg;
    core_next.sleep_s1 = sleep_control_pin;
    core_next.sleep_s2 = core_reg.sleep_s1;
    core_next.drv_s1 = driver_disable_pin;
    core_next.drv_s2 = core_reg.drv_s1;
    core_next.cs_s1 = chip_select_low;
    core_next.cs_s2 = core_reg.cs_s1;
    core_next.cs_prev = core_reg.cs_s2;
    core_next.clear_pulse = 1'b0;
    core_next.timer = core_reg.timer + 32'h0000_0001;

    // Latched flags: a set in the clearing cycle wins.
    if (core_reg.clear_pulse) begin
      core_next.frame_err = 1'b0; // see RL19
      core_next.addr_err = 1'b0; // see RL20
      core_next.parity_err = 1'b0; // see RL24
      core_next.por_flag = 1'b1; // see RL22
    end

    unique case (core_reg.mode)
      MD_SLEEP: begin
        if (core_reg.sleep_s2) begin
          core_next.mode = MD_WAKING; // see RL3
          core_next.timer = '0;
        end
      end
      MD_WAKING: begin
        if (!core_reg.sleep_s2) begin
          core_next.mode = MD_SLEEP; // see RL1
        end else if (core_reg.timer >= TMR_W'(WAKE_T - 1)) begin
          core_next.mode = MD_ACTIVE; // see RL3, RL5
        end
      end
      MD_ACTIVE: begin
        if (!core_reg.sleep_s2) begin
          core_next.mode = MD_PULSE;
          core_next.timer = '0;
        end
      end
      MD_PULSE: begin
        if (core_reg.sleep_s2) begin
          // Short low: fault reset only, settings untouched.
          core_next.mode = MD_ACTIVE; // see RL7
          core_next.clear_pulse = 1'b1; // see RL6, RL8
        end else if (core_reg.timer >= TMR_W'(RST_T - 1)) begin
          core_next.mode = MD_ENTERING; // see RL7
        end
      end
      MD_ENTERING: begin
        // Entry runs to completion even if the pin rises again.
        if (core_reg.timer >= TMR_W'(SLEEP_T - 1)) begin
          core_next.mode = MD_SLEEP; // see RL1, RL3
        end
      end
    endcase

    // Frame start: freeze the status snapshot for the reply.
    if (!core_reg.link_run && spi_ok && core_reg.cs_prev &&
        !core_reg.cs_s2) begin
      core_next.link_run = 1'b1;
      core_next.snap[0] = ic_top_live;
      core_next.snap[1] = drv_live;
      core_next.snap[2] = sup_live;
    end

    // Frame end: the link is idle, so its word is stable here.
    if (core_reg.link_run && !spi_ok) begin
      core_next.link_run = 1'b0;
    end else if (core_reg.link_run && core_reg.cs_s2) begin
      core_next.link_run = 1'b0;
      if (rx_reg.count != FRAME_LEN) begin
        core_next.frame_err = 1'b1; // see RL19
      end else if (^rx_reg.shift) begin
        core_next.parity_err = 1'b1; // see RL24
      end else if (fr_addr > OFS_LAST) begin
        core_next.addr_err = 1'b1; // see RL20
      end else if (!rx_reg.shift[RW_POS] &&
                   fr_addr >= OFS_CTRL_FIRST) begin
        // see RL12
        core_next.ctrl[fr_idx] = fr_data;
        if (fr_addr == OFS_CLEAR) begin
          // Clear-faults is a command, it never reads back as set.
          core_next.ctrl[fr_idx][CLEAR_POS] = 1'b0;
          core_next.clear_pulse = fr_data[CLEAR_POS]; // see RL6
        end
      end
    end

    // Sleep brings every register back to its default.
    if (core_next.mode == MD_SLEEP) begin
      core_next.ctrl = CTRL_RESET; // see RL21
      core_next.frame_err = 1'b0;
      core_next.addr_err = 1'b0;
      core_next.parity_err = 1'b0;
      core_next.por_flag = 1'b0;
      core_next.link_run = 1'b0; // see RL2
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reg <= '0;
      core_reg.mode <= MD_SLEEP;
      core_reg.ctrl <= '0;
      core_reg.snap <= '0;
    end else if (ce) begin
      core_reg <= core_next;
    end
  end

  // ----------------------------------------------------------------
  // Core outputs
  // ----------------------------------------------------------------
  always_comb begin
    power.regs_on = (core_reg.mode != MD_SLEEP); // see RL2, RL5
    power.spi_on = spi_ok;
    power.ready = spi_ok;
    power.drv_fault_mask = core_reg.drv_s2; // see RL9
    power.switches_on = spi_ok && !core_reg.drv_s2; // see RL9
  end

  assign clear_faults_pulse = core_reg.clear_pulse;
  // Low drive during regulator ramps and while a fault is reported.
  assign fault_indicator_pin_oe_b =
    !((core_reg.mode == MD_WAKING) || (core_reg.mode == MD_ENTERING) ||
      prot_in.global_fault); // see RL4

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // The link sits in reset outside a frame; a stray clock while chip
  // select is high then changes nothing. The release is asynchronous to
  // the serial clock, which is low at that moment.
  assign link_rst_b = core_reg.link_run; // see RL16

  always_comb begin
    rx_next = rx_reg;
    rx_next.shift = {rx_reg.shift[14:0], spi_sdi}; // see RL17, RL18
    if (rx_reg.count != FRAME_SAT) begin
      rx_next.count = rx_reg.count + 5'h01;
    end
    if (rx_next.count == ADDR_DONE) begin
      rx_next.addr = {rx_reg.shift[4:0], spi_sdi};
    end
  end

  always_ff @(negedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (rx_reg.addr <= OFS_LAST) begin
      rd_byte = reg_view[rx_reg.addr[3:0]];
    end
    reply = {core_reg.snap[0], rd_byte}; // see RL13
    tx_next = tx_reg;
    tx_next.sdo = 1'b0;
    if (rx_reg.count < FRAME_LEN) begin
      // see RL17, RL18
      tx_next.sdo = reply[4'(4'hF - rx_reg.count[3:0])];
    end
  end

  always_ff @(posedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      tx_reg <= '0;
    end else begin
      tx_reg <= tx_next;
    end
  end

  assign spi_sdo = tx_reg.sdo;
  assign spi_sdo_oe_b = chip_select_low || !core_reg.link_run; // see RL16

endmodule

`default_nettype wire

// [mdsc_spi_mode_checker.sv]
// Checker of the mode pins, power controls and serial output enable.
`timescale 1ns/1ps
`default_nettype none

module mdsc_spi_mode_checker
  import mdsc_pkg::*;
#(
  parameter int WAKE_T = 20
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Mode pins.
  input wire logic sleep_control_pin,
  input wire logic driver_disable_pin,
  input wire logic fault_indicator_pin_oe_b,
  // Serial port.
  input wire logic spi_sclk,
  input wire logic chip_select_low,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_b,
  // Protection side.
  input wire mdsc_prot_in_t prot_in,
  input wire logic clear_faults_pulse,
  input wire mdsc_power_t power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Counts the cycles spent ramping, so the wake delay is measured exactly.
  logic [7:0] wake_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt <= 8'h00;
    end else if (power.regs_on && !power.ready) begin
      wake_cnt <= wake_cnt + 8'h01;
    end else begin
      wake_cnt <= 8'h00;
    end
  end

  a_sdo_float_idle: assert property (
    chip_select_low |-> spi_sdo_oe_b) else $error("sdo driven idle");
  a_disable_kills_switches: assert property (
    driver_disable_pin [*3] |-> !power.switches_on)
    else $error("switches on while disabled");
  a_disable_masks_faults: assert property (
    driver_disable_pin [*3] |-> power.drv_fault_mask)
    else $error("driver faults not masked");
  a_sleep_all_off: assert property (
    !power.regs_on |-> !power.spi_on && !power.switches_on)
    else $error("block active in sleep");
  a_ready_needs_regs: assert property (
    power.ready |-> power.regs_on && power.spi_on)
    else $error("ready without supplies");
  a_fault_low_ramp: assert property (
    power.regs_on && !power.ready |-> !fault_indicator_pin_oe_b)
    else $error("fault pin released while ramping");
  a_wake_delay_count: assert property (
    $rose(power.ready) |-> wake_cnt >= 8'(WAKE_T) &&
      wake_cnt <= 8'(WAKE_T + 1)) else $error("wake delay wrong");
  a_clear_pulse_single: assert property (
    clear_faults_pulse |=> !clear_faults_pulse)
    else $error("clear pulse too long");
  a_fault_on_global: assert property (
    prot_in.global_fault |-> !fault_indicator_pin_oe_b)
    else $error("fault pin not low on fault");

  c_wake: cover property ($rose(power.ready));
  c_clear: cover property (clear_faults_pulse);
  c_disable: cover property (driver_disable_pin && !power.switches_on);
endmodule

`default_nettype wire

// [mdsc_spi_ctl_model.sv]
// Serial controller model that frames words into the port.
`timescale 1ns/1ps
`default_nettype none

module mdsc_spi_ctl_model (
  // Serial lines.
  output logic spi_sclk,
  output logic chip_select_low,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial begin
    spi_sclk = 1'b0;
    chip_select_low = 1'b1;
    spi_sdi = 1'b0;
  end

  // The clock runs only inside a frame; between frames the data line
  // shows the inverse of its last bit, so a stale value never passes.
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [15:0] r);
    r = 16'h0000;
    #7 chip_select_low = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      spi_sclk = 1'b1;
      spi_sdi = w[15 - i];
      #32 r = {r[14:0], spi_sdo};
      spi_sclk = 1'b0;
      #32;
    end
    chip_select_low = 1'b1;
    spi_sdi = ~spi_sdi;
    #500;
  endtask
endmodule

`default_nettype wire

// [mdsc_spi_mode_tb_top.sv]
// Top testbench of the serial port and mode control block.
`timescale 1ns/1ps
`default_nettype none

module mdsc_spi_mode_tb_top
  import mdsc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sleep_pin = 1'b1;
  logic drv_off = 1'b0;
  logic sclk, cs_b, sdi, sdo, sdo_oe_b, fault_oe_b, clr_pulse;
  mdsc_prot_in_t prot = '0;
  mdsc_power_t pwr;
  int fail_count = 0;
  int samples_checked = 0;
  logic [15:0] rep;

  always #2 clk = ~clk;

  mdsc_spi_mode #(.SLEEP_T(40), .WAKE_T(20), .RST_T(10)) uut (
    .clk(clk), .rst_b(rst_b), .ce(1'b1),
    .sleep_control_pin(sleep_pin), .driver_disable_pin(drv_off),
    .fault_indicator_pin_oe_b(fault_oe_b),
    .spi_sclk(sclk), .chip_select_low(cs_b), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe_b(sdo_oe_b),
    .prot_in(prot), .clear_faults_pulse(clr_pulse), .power(pwr));

  mdsc_spi_ctl_model ctl (
    .spi_sclk(sclk), .chip_select_low(cs_b), .spi_sdi(sdi),
    .spi_sdo(sdo));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic rw, input logic [5:0] a,
                      input logic [7:0] d, input logic bad,
                      input logic [15:0] exp);
    logic [15:0] w;
    w = {rw, a, 1'b0, d};
    w[8] = (^w) ^ bad;
    ctl.frame(w, 16, rep);
    check("reply", exp, rep);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (pwr.ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) begin
      check("ready", 16'h0001, 16'h0000);
      report_and_stop();
    end
  endtask

  task automatic set_sleep(input logic v, input int n);
    @(posedge clk);
    sleep_pin <= v;
    repeat (n) @(posedge clk);
  endtask

  initial begin
    prot.motor_stall = 1'b1;
    prot.overvoltage = 1'b1;
    prot.drv_status = 8'h3c;
    prot.supply_status = 4'h5;
    repeat (10) @(posedge clk);
    check("power", 16'h0000, {11'h000, pwr});
    check("fault_oe", 16'h0001, {15'h0000, fault_oe_b});
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    check("fault_oe", 16'h0000, {15'h0000, fault_oe_b});
    wait_ready();
    check("fault_oe", 16'h0001, {15'h0000, fault_oe_b});
    xfer(1'b1, 6'h00, 8'h00, 1'b0, 16'h8484);
    xfer(1'b1, 6'h01, 8'h00, 1'b0, 16'h843c);
    xfer(1'b1, 6'h02, 8'h00, 1'b0, 16'h8428);
    xfer(1'b0, 6'h04, 8'ha5, 1'b0, 16'h8400);
    xfer(1'b1, 6'h04, 8'h00, 1'b0, 16'h84a5);
    xfer(1'b0, 6'h05, 8'h11, 1'b1, 16'h8400);
    xfer(1'b1, 6'h02, 8'h00, 1'b0, 16'ha42c);
    xfer(1'b0, 6'h03, 8'h01, 1'b0, 16'ha400);
    xfer(1'b1, 6'h02, 8'h00, 1'b0, 16'h8c28);
    ctl.frame({1'b0, 6'h04, 9'h000}, 8, rep);
    xfer(1'b1, 6'h02, 8'h00, 1'b0, 16'hac2a);
    xfer(1'b1, 6'h20, 8'h00, 1'b0, 16'hac00);
    xfer(1'b1, 6'h02, 8'h00, 1'b0, 16'hac2b);
    set_sleep(1'b0, 5);
    set_sleep(1'b1, 20);
    check("ready", 16'h0001, {15'h0000, pwr.ready});
    xfer(1'b1, 6'h02, 8'h00, 1'b0, 16'h8c28);
    xfer(1'b1, 6'h04, 8'h00, 1'b0, 16'h8ca5);
    @(posedge clk);
    drv_off <= 1'b1;
    repeat (5) @(posedge clk);
    check("drv_pwr", 16'h001b, {11'h000, pwr});
    @(posedge clk);
    drv_off <= 1'b0;
    prot.global_fault <= 1'b1;
    repeat (3) @(posedge clk);
    check("fault_oe", 16'h0000, {15'h0000, fault_oe_b});
    prot.global_fault <= 1'b0;
    set_sleep(1'b0, 80);
    check("power", 16'h0000, {11'h000, pwr});
    check("sdo_oe", 16'h0001, {15'h0000, sdo_oe_b});
    set_sleep(1'b1, 2);
    wait_ready();
    xfer(1'b1, 6'h04, 8'h00, 1'b0, 16'h8400);
    report_and_stop();
  end
endmodule

bind mdsc_spi_mode mdsc_spi_mode_checker #(.WAKE_T(20)) chk (
  .clk(clk), .rst_b(rst_b), .ce(ce),
  .sleep_control_pin(sleep_control_pin),
  .driver_disable_pin(driver_disable_pin),
  .fault_indicator_pin_oe_b(fault_indicator_pin_oe_b),
  .spi_sclk(spi_sclk), .chip_select_low(chip_select_low),
  .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_b(spi_sdo_oe_b),
  .prot_in(prot_in), .clear_faults_pulse(clear_faults_pulse),
  .power(power));

`default_nettype wire
